// >>> pcm_codec_dev.sv
// pcm_codec_dev: digital side of the codec, companding and serial framing
// assumes all pins are asynchronous to mclk and bit clocks are far below mclk
`timescale 1ns/100ps
`include "pcm_cfg.svh"
module pcm_codec_dev (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	// serial pins
	pcm_if.dev pins,
	// linear sample side
	input wire logic [15:0] tx_sample,
	output logic tx_take,
	output logic [15:0] rx_sample,
	output logic rx_valid,
	// status
	output pcm_pkg::pcm_mode_type mode,
	output logic channel,
	output logic powered,
	output logic [15:0] frame_period
);

	// mu-law compression of a 16-bit linear sample
	function automatic logic [7:0] mu_enc(input logic [15:0] x);
		logic [15:0] m;
		logic [13:0] mg;
		logic [14:0] b;
		logic [14:0] sh;
		logic [2:0] seg;
		m = x[15] ? (~x + 16'h0001) : x;
		mg = (m[15:2] > `PCM_MU_CLIP) ? `PCM_MU_CLIP : m[15:2];
		b = {1'b0, mg} + 15'h0021;
		seg = 3'h0;
		for (int i = 1; i < 8; i++) begin
			if (b[i + 5])
				seg = i[2:0];
		end
		sh = b >> (seg + 3'h1);
		mu_enc = {~x[15], ~seg, ~sh[3:0]};
	endfunction

	// a-law compression of a 16-bit linear sample
	function automatic logic [7:0] a_enc(input logic [15:0] x);
		logic [15:0] m;
		logic [11:0] mg;
		logic [11:0] sh;
		logic [2:0] seg;
		m = x[15] ? (~x + 16'h0001) : x;
		mg = m[15] ? 12'hFFF : m[14:3];
		seg = 3'h0;
		for (int i = 1; i < 8; i++) begin
			if (mg[i + 4])
				seg = i[2:0];
		end
		sh = (seg == 3'h0) ? (mg >> 1) : (mg >> seg);
		a_enc = {~x[15], seg, sh[3:0]} ^ `PCM_A_TOGGLE;
	endfunction

	// mu-law expansion to 16-bit linear
	function automatic logic [15:0] mu_dec(input logic [7:0] c);
		logic [7:0] u;
		logic [15:0] t;
		logic [15:0] mag;
		u = ~c;
		t = ({9'h000, u[3:0], 3'h0} + `PCM_MU_BIAS) << u[6:4];
		mag = t - `PCM_MU_BIAS;
		mu_dec = u[7] ? (~mag + 16'h0001) : mag;
	endfunction

	// a-law expansion to 16-bit linear
	function automatic logic [15:0] a_dec(input logic [7:0] c);
		logic [7:0] u;
		logic [15:0] t;
		u = c ^ `PCM_A_TOGGLE;
		t = {8'h00, u[3:0], 4'h8};
		if (u[6:4] != 3'h0)
			t = (t + 16'h0100) << (u[6:4] - 3'h1);
		a_dec = u[7] ? t : (~t + 16'h0001);
	endfunction

	// pin synchroniser: meta, stable, previous
	logic [6:0] meta_q, sync_q, prev_q;
	wire [6:0] pin_w = {pins.rx_bit_clock_pin, pins.tx_bit_clock_pin, pins.rx_frame_sync,
		pins.tx_frame_sync, pins.serial_data_in, pins.law_select, pins.power_up_input};

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			meta_q <= 7'h00;
			sync_q <= 7'h00;
			prev_q <= 7'h00;
		end else if (ce) begin
			meta_q <= pin_w;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// pin views and edges, timing only from clocks and syncs
	wire rxck_w = sync_q[6];
	wire txck_w = sync_q[5];
	wire rxfs_w = sync_q[4];
	wire din_w = sync_q[2];
	wire law_mu_w = sync_q[1];
	wire pwr_w = sync_q[0];
	wire tx_rise_w = txck_w & ~prev_q[5];
	wire txfs_rise_w = sync_q[3] & ~prev_q[3];
	wire rxfs_rise_w = rxfs_w & ~prev_q[4];
	wire rxck_edge_w = rxck_w ^ prev_q[6];

	// format detection state
	logic seen_q;
	logic [1:0] static_q;
	pcm_pkg::pcm_mode_type mode_q;
	logic chan_q;
	wire seen_w = seen_q | rxck_edge_w;
	wire [1:0] static_d = seen_w ? 2'h0 :
		((static_q == `PCM_STATIC_FRAMES) ? static_q : static_q + 2'h1);
	wire static_w = (static_d == `PCM_STATIC_FRAMES);
	pcm_pkg::pcm_mode_type mode_d;
	assign mode_d = !static_w ? pcm_pkg::PCM_FRAME :
		(rxck_w ? pcm_pkg::PCM_IDL : pcm_pkg::PCM_GCI);
	wire chan_d = static_w & rxfs_w;
	pcm_pkg::pcm_mode_type cur_mode;
	assign cur_mode = txfs_rise_w ? mode_d : mode_q;
	wire cur_chan = txfs_rise_w ? chan_d : chan_q;
	wire isdn_w = (cur_mode != pcm_pkg::PCM_FRAME);
	wire wide_w = (cur_mode == pcm_pkg::PCM_GCI);
	wire [7:0] start_w = pcm_pkg::pcm_slot_start(cur_mode, cur_chan);

	// mode and channel latched only on frame starts
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			seen_q <= 1'b0;
			static_q <= 2'h0;
			mode_q <= pcm_pkg::PCM_FRAME;
			chan_q <= 1'b0;
		end else if (ce) begin
			seen_q <= txfs_rise_w ? rxck_edge_w : seen_w;
			if (txfs_rise_w) begin
				static_q <= static_d;
				mode_q <= mode_d;
				chan_q <= chan_d;
			end
		end
	end

	// power-down guard: line stays released for whole frames after power-up
	logic [1:0] guard_q;
	logic drive_ok_q;
	wire drive_ok_d = txfs_rise_w ? (guard_q == `PCM_GUARD_FRAMES) : drive_ok_q;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			guard_q <= 2'h0;
			drive_ok_q <= 1'b0;
		end else if (ce) begin
			if (!pwr_w) begin
				guard_q <= 2'h0;
				drive_ok_q <= 1'b0;
			end else if (txfs_rise_w) begin
				drive_ok_q <= drive_ok_d;
				if (guard_q != `PCM_GUARD_FRAMES)
					guard_q <= guard_q + 2'h1;
			end
		end
	end

	// frame period measured in mclk cycles, the prescaler lock
	logic [15:0] per_cnt_q, period_q;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			per_cnt_q <= 16'h0000;
			period_q <= 16'h0000;
		end else if (ce) begin
			if (txfs_rise_w) begin
				period_q <= per_cnt_q + 16'h0001;
				per_cnt_q <= 16'h0000;
			end else if (per_cnt_q != 16'hFFFF) begin
				per_cnt_q <= per_cnt_q + 16'h0001;
			end
		end
	end

	// transmit: encode at frame start, clock out on rising edges
	logic [7:0] code_q;
	logic [7:0] tcnt_q;
	logic dout_q, oe_q;
	wire [7:0] enc_w = law_mu_w ? mu_enc(tx_sample) : a_enc(tx_sample);
	wire [7:0] word_w = txfs_rise_w ? enc_w : code_q;
	wire [7:0] tcnt_d = txfs_rise_w ? 8'h00 : ((tcnt_q == 8'hFF) ? tcnt_q : tcnt_q + 8'h01);
	wire [3:0] tpos_w = pcm_pkg::pcm_bit_at(tcnt_d - start_w, wide_w, 1'b0);
	wire tx_edge_w = txfs_rise_w | tx_rise_w;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			code_q <= 8'h00;
			tcnt_q <= 8'h00;
			dout_q <= 1'b1;
			oe_q <= 1'b0;
		end else if (ce) begin
			if (txfs_rise_w)
				code_q <= enc_w;
			if (!pwr_w) begin
				oe_q <= 1'b0;
			end else if (tx_edge_w) begin
				tcnt_q <= tcnt_d;
				dout_q <= tpos_w[3] ? word_w[3'h7 - tpos_w[2:0]] : 1'b1;
				oe_q <= tpos_w[3] & drive_ok_d;
			end
		end
	end

	// receive: isdn formats share the transmit clock and sync
	wire rclk_w = isdn_w ? txck_w : rxck_w;
	wire rclk_prev_w = isdn_w ? prev_q[5] : prev_q[6];
	wire rx_fall_w = ~rclk_w & rclk_prev_w;
	wire rfr_rise_w = isdn_w ? txfs_rise_w : rxfs_rise_w;
	logic [7:0] rcnt_q;
	logic [7:0] shift_q;
	logic [15:0] rx_sample_q;
	logic rx_valid_q;
	wire [7:0] rcnt_d = (rcnt_q == 8'hFF) ? rcnt_q : rcnt_q + 8'h01;
	wire [3:0] rpos_w = pcm_pkg::pcm_bit_at(rcnt_d - start_w - 8'h01, wide_w, 1'b1);
	wire rx_hit_w = pwr_w & rx_fall_w & rpos_w[3];
	wire [7:0] rx_word_w = {shift_q[7:1], din_w};

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rcnt_q <= 8'h00;
			shift_q <= 8'h00;
			rx_sample_q <= 16'h0000;
			rx_valid_q <= 1'b0;
		end else if (ce) begin
			rx_valid_q <= 1'b0;
			if (rfr_rise_w)
				rcnt_q <= 8'h00;
			else if (rx_fall_w)
				rcnt_q <= rcnt_d;
			if (rx_hit_w)
				shift_q[3'h7 - rpos_w[2:0]] <= din_w;
			if (rx_hit_w && rpos_w[2:0] == 3'h7) begin
				rx_sample_q <= law_mu_w ? mu_dec(rx_word_w) : a_dec(rx_word_w);
				rx_valid_q <= 1'b1;
			end
		end
	end

	// outputs
	assign tx_take = ce & pwr_w & txfs_rise_w;
	assign rx_sample = rx_sample_q;
	assign rx_valid = rx_valid_q;
	assign mode = mode_q;
	assign channel = chan_q;
	assign powered = pwr_w;
	assign frame_period = period_q;
	assign pins.serial_data_out_o = dout_q;
	assign pins.serial_data_out_oe = oe_q;
endmodule

// >>> pcm_cfg.svh
// pcm_cfg.svh: timing counts, slot positions and guard counts of the pcm link
// assumes a 10 MHz mclk shared by both ends of the link
`ifndef PCM_CFG_SVH
`define PCM_CFG_SVH
`define PCM_CLK_NS 100
`define PCM_FRAME_NS 125000
`define PCM_FRAME_CYCLES (`PCM_FRAME_NS / `PCM_CLK_NS)
`define PCM_BCLK_HALF 5
`define PCM_FRAME_BITS (`PCM_FRAME_CYCLES / (2 * `PCM_BCLK_HALF))
`define PCM_SLOT_FRAME 8'h01
`define PCM_SLOT_GCI_B1 8'h00
`define PCM_SLOT_GCI_B2 8'h10
`define PCM_SLOT_IDL_B1 8'h01
`define PCM_SLOT_IDL_B2 8'h0B
`define PCM_STATIC_FRAMES 2'h2
`define PCM_GUARD_FRAMES 2'h2
`define PCM_MU_CLIP 14'h1FDE
`define PCM_MU_BIAS 16'h0084
`define PCM_A_TOGGLE 8'h55
`endif

// >>> pcm_pkg.sv
// pcm_pkg: link mode type and slot helpers shared by both ends
// assumes pcm_cfg.svh is on the include path
`include "pcm_cfg.svh"
package pcm_pkg;
	typedef enum logic [1:0] {PCM_FRAME = 2'b00, PCM_GCI = 2'b01, PCM_IDL = 2'b11} pcm_mode_type;

	// first bit-clock edge of the active slot
	function automatic logic [7:0] pcm_slot_start(input pcm_mode_type m, input logic ch);
		case (m)
			PCM_GCI: pcm_slot_start = ch ? `PCM_SLOT_GCI_B2 : `PCM_SLOT_GCI_B1;
			PCM_IDL: pcm_slot_start = ch ? `PCM_SLOT_IDL_B2 : `PCM_SLOT_IDL_B1;
			default: pcm_slot_start = `PCM_SLOT_FRAME;
		endcase
	endfunction

	// {hit, bit index} for an edge offset into the slot; gci bits last two clocks
	function automatic logic [3:0] pcm_bit_at(input logic [7:0] rel, input logic wide, input logic sample);
		if (wide)
			pcm_bit_at = {(rel < 8'h10) && (!sample || rel[0]), rel[3:1]};
		else
			pcm_bit_at = {rel < 8'h08, rel[2:0]};
	endfunction
endpackage

// >>> pcm_if.sv
// pcm_if: the serial pins between codec and highway controller
// assumes serial_data_out is pulled high while nobody drives it
`timescale 1ns/100ps
interface pcm_if;
	logic rx_bit_clock_pin;
	logic tx_bit_clock_pin;
	logic rx_frame_sync;
	logic tx_frame_sync;
	logic serial_data_in;
	logic serial_data_out_o;
	logic serial_data_out_oe;
	logic law_select;
	logic power_up_input;
	wire serial_data_out;

	// resolved line level, pull-up when released
	assign serial_data_out = serial_data_out_oe ? serial_data_out_o : 1'b1;

	modport dev (
		input rx_bit_clock_pin, tx_bit_clock_pin, rx_frame_sync, tx_frame_sync,
		input serial_data_in, law_select, power_up_input,
		output serial_data_out_o, serial_data_out_oe
	);
	modport host (
		output rx_bit_clock_pin, tx_bit_clock_pin, rx_frame_sync, tx_frame_sync,
		output serial_data_in, law_select, power_up_input,
		input serial_data_out
	);
endinterface

// >>> pcm_highway_host.sv
// pcm_highway_host: highway controller end, makes bit clock and frame sync
// assumes the codec end shares mclk; codec output is resampled through two flops
`timescale 1ns/100ps
`include "pcm_cfg.svh"
module pcm_highway_host #(
	parameter int BCLK_HALF = `PCM_BCLK_HALF,
	parameter int FRAME_BITS = `PCM_FRAME_BITS
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	// serial pins
	pcm_if.host pins,
	// control
	input pcm_pkg::pcm_mode_type mode_sel,
	input wire logic chan_sel,
	input wire logic law_mu,
	input wire logic power_up,
	// byte side
	input wire logic [7:0] tx_byte,
	output logic tx_take,
	output logic [7:0] rx_byte,
	output logic rx_valid
);

	logic [7:0] div_q, bit_q, byte_q, cap_q, rx_byte_q;
	logic bclk_q, txfs_q, rxfs_q, rxck_q, din_q, law_q, pwr_q, rx_valid_q, chan_q;
	logic meta_q, dout_q;
	pcm_pkg::pcm_mode_type mode_q;

	// bit clock divider and bit position in the frame
	wire rise_w = (div_q == 8'(2 * BCLK_HALF - 1));
	wire fall_w = (div_q == 8'(BCLK_HALF - 1));
	wire [7:0] bnext_w = (bit_q == 8'(FRAME_BITS - 1)) ? 8'h00 : bit_q + 8'h01;
	wire frame_w = rise_w && (bnext_w == 8'h00);
	pcm_pkg::pcm_mode_type cur_mode;
	assign cur_mode = frame_w ? mode_sel : mode_q;
	wire cur_chan = frame_w ? chan_sel : chan_q;
	wire isdn_w = (cur_mode != pcm_pkg::PCM_FRAME);
	wire wide_w = (cur_mode == pcm_pkg::PCM_GCI);
	wire [7:0] start_w = pcm_pkg::pcm_slot_start(cur_mode, cur_chan);
	wire [7:0] word_w = frame_w ? tx_byte : byte_q;
	wire [3:0] tpos_w = pcm_pkg::pcm_bit_at(bnext_w - start_w, wide_w, 1'b0);
	wire [3:0] cpos_w = pcm_pkg::pcm_bit_at(bnext_w - start_w - 8'h01, wide_w, 1'b1);

	// clocks, syncs and mode straps toward the codec
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			div_q <= 8'h00;
			bit_q <= 8'h00;
			bclk_q <= 1'b0;
			txfs_q <= 1'b0;
			rxfs_q <= 1'b0;
			rxck_q <= 1'b0;
			law_q <= 1'b0;
			pwr_q <= 1'b0;
			mode_q <= pcm_pkg::PCM_FRAME;
			chan_q <= 1'b0;
		end else if (ce) begin
			law_q <= law_mu;
			pwr_q <= power_up;
			div_q <= rise_w ? 8'h00 : div_q + 8'h01;
			if (frame_w) begin
				mode_q <= mode_sel;
				chan_q <= chan_sel;
			end
			if (rise_w) begin
				bit_q <= bnext_w;
				bclk_q <= 1'b1;
				txfs_q <= (bnext_w == 8'h00);
				rxfs_q <= isdn_w ? cur_chan : (bnext_w == 8'h00);
				rxck_q <= isdn_w ? (cur_mode == pcm_pkg::PCM_IDL) : 1'b1;
			end else if (fall_w) begin
				bclk_q <= 1'b0;
				rxck_q <= isdn_w ? (cur_mode == pcm_pkg::PCM_IDL) : 1'b0;
			end
		end
	end

	// data toward the codec and capture of the codec's output
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			byte_q <= 8'h00;
			din_q <= 1'b1;
			meta_q <= 1'b1;
			dout_q <= 1'b1;
			cap_q <= 8'h00;
			rx_byte_q <= 8'h00;
			rx_valid_q <= 1'b0;
		end else if (ce) begin
			meta_q <= pins.serial_data_out;
			dout_q <= meta_q;
			rx_valid_q <= 1'b0;
			if (frame_w)
				byte_q <= tx_byte;
			if (rise_w) begin
				din_q <= tpos_w[3] ? word_w[3'h7 - tpos_w[2:0]] : 1'b1;
				if (cpos_w[3])
					cap_q[3'h7 - cpos_w[2:0]] <= dout_q;
				if (cpos_w[3] && cpos_w[2:0] == 3'h7) begin
					rx_byte_q <= {cap_q[7:1], dout_q};
					rx_valid_q <= 1'b1;
				end
			end
		end
	end

	// outputs
	assign tx_take = ce & frame_w;
	assign rx_byte = rx_byte_q;
	assign rx_valid = rx_valid_q;
	assign pins.tx_bit_clock_pin = bclk_q;
	assign pins.tx_frame_sync = txfs_q;
	assign pins.rx_frame_sync = rxfs_q;
	assign pins.rx_bit_clock_pin = rxck_q;
	assign pins.serial_data_in = din_q;
	assign pins.law_select = law_q;
	assign pins.power_up_input = pwr_q;
endmodule

// >>> pcm_link_props.sv
// pcm_link_props: concurrent checks on the serial pins between codec and highway ends
// assumes the host runs with BCLK_HALF 5 and FRAME_CYCLES equal to its frame length in mclk cycles
`timescale 1ns/100ps
module pcm_link_props #(
	parameter int FRAME_CYCLES = 1250
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// host driven pins
	input wire logic rx_bit_clock_pin,
	input wire logic tx_bit_clock_pin,
	input wire logic rx_frame_sync,
	input wire logic tx_frame_sync,
	input wire logic serial_data_in,
	input wire logic law_select,
	input wire logic power_up_input,
	// codec driven pins
	input wire logic serial_data_out_o,
	input wire logic serial_data_out_oe,
	input wire logic serial_data_out
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic sync_prev_q, oe_prev_q, seen_q;
	logic [15:0] gap_q;
	logic [1:0] guard_q, oe_rises_q;
	logic [7:0] oe_len_q;
	wire sync_rise = tx_frame_sync && !sync_prev_q;
	wire oe_rise = serial_data_out_oe && !oe_prev_q;

	// frame gap, sync rises since power-up, output bursts per frame and burst length
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sync_prev_q <= 1'b0;
			oe_prev_q <= 1'b0;
			seen_q <= 1'b0;
			gap_q <= 16'h0000;
			guard_q <= 2'h0;
			oe_rises_q <= 2'h0;
			oe_len_q <= 8'h00;
		end else begin
			sync_prev_q <= tx_frame_sync;
			oe_prev_q <= serial_data_out_oe;
			seen_q <= seen_q || sync_rise;
			gap_q <= sync_rise ? 16'h0000 : gap_q + 16'h0001;
			guard_q <= !power_up_input ? 2'h0 : ((sync_rise && guard_q != 2'h3) ? guard_q + 2'h1 : guard_q);
			oe_rises_q <= sync_rise ? 2'h0 : ((oe_rises_q == 2'h3) ? 2'h3 : oe_rises_q + {1'b0, oe_rise});
			oe_len_q <= serial_data_out_oe ? ((oe_len_q == 8'hFF) ? 8'hFF : oe_len_q + 8'h01) : 8'h00;
		end
	end

	reset_quiet_a: assert property ($rose(rst_n) |-> !serial_data_out_oe)
		else $error("output driven at reset release");
	power_quiet_a: assert property ((!power_up_input) [*4] |-> !serial_data_out_oe)
		else $error("output driven while powered down");
	guard_frames_a: assert property (serial_data_out_oe && power_up_input |-> guard_q == 2'h3)
		else $error("output driven before two frames after power-up");
	edge_launch_a: assert property ($rose(serial_data_out_oe) |-> tx_bit_clock_pin)
		else $error("output enabled away from a bit clock rise");
	bit_change_a: assert property (serial_data_out_oe && $past(serial_data_out_oe) && $changed(serial_data_out_o)
		|-> tx_bit_clock_pin)
		else $error("data bit changed away from a bit clock rise");
	word_length_a: assert property ($fell(serial_data_out_oe) && power_up_input |-> oe_len_q >= 8'd75 && oe_len_q <= 8'd165)
		else $error("output burst not one eight bit word");
	one_word_a: assert property (oe_rises_q <= 2'h1)
		else $error("more than one word sent in a frame");
	frame_period_a: assert property (sync_rise && seen_q |-> gap_q == FRAME_CYCLES - 1)
		else $error("frame sync period wrong");
	sync_width_a: assert property ($rose(tx_frame_sync) |-> tx_frame_sync ##9 tx_frame_sync ##1 !tx_frame_sync)
		else $error("frame sync not one bit clock wide");
	sync_on_edge_a: assert property ($rose(tx_frame_sync) |-> $rose(tx_bit_clock_pin))
		else $error("frame sync not on a bit clock rise");
endmodule

// >>> tb_top.sv
// tb_top: joins codec and highway ends over pcm_if and loops words through every link format
// assumes both ends share mclk; the host frame is shortened to 40 bit clocks
`timescale 1ns/100ps
module tb_top;
	localparam int FBITS = 40;
	localparam int FRAME = FBITS * 10;
	logic mclk, rst_n, chan_sel, law_mu, power_up, channel, powered, dev_rx_valid, host_rx_valid;
	logic dev_take, host_take;
	int tx_n, htx_n;
	logic [15:0] tx_sample, dev_rx_sample, frame_period, got_sample;
	logic [7:0] tx_byte, host_rx_byte, got_byte;
	pcm_pkg::pcm_mode_type dev_mode, mode_sel;
	int fail_count, cmp_count, dev_rx_n, k, w;
	pcm_if link ();

	// the two ends and the pin checker
	pcm_codec_dev pcm_codec_dev_inst (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .pins(link.dev), .tx_sample(tx_sample),
		.tx_take(dev_take), .rx_sample(dev_rx_sample), .rx_valid(dev_rx_valid), .mode(dev_mode), .channel(channel),
		.powered(powered), .frame_period(frame_period));
	pcm_highway_host #(.BCLK_HALF(5), .FRAME_BITS(FBITS)) pcm_highway_host_inst (.mclk(mclk), .rst_n(rst_n), .ce(1'b1),
		.pins(link.host), .mode_sel(mode_sel), .chan_sel(chan_sel), .law_mu(law_mu), .power_up(power_up),
		.tx_byte(tx_byte), .tx_take(host_take), .rx_byte(host_rx_byte), .rx_valid(host_rx_valid));
	pcm_link_props #(.FRAME_CYCLES(FRAME)) pcm_link_props_inst (.mclk(mclk), .rst_n(rst_n),
		.rx_bit_clock_pin(link.rx_bit_clock_pin), .tx_bit_clock_pin(link.tx_bit_clock_pin),
		.rx_frame_sync(link.rx_frame_sync), .tx_frame_sync(link.tx_frame_sync), .serial_data_in(link.serial_data_in),
		.law_select(link.law_select), .power_up_input(link.power_up_input), .serial_data_out_o(link.serial_data_out_o),
		.serial_data_out_oe(link.serial_data_out_oe), .serial_data_out(link.serial_data_out));

	// 10 MHz clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// latch the last word seen at each end and count codec receive pulses
	always @(posedge mclk) begin
		if (host_rx_valid === 1'b1) got_byte <= host_rx_byte;
		if (dev_take === 1'b1) tx_n <= tx_n + 1;
		if (host_take === 1'b1) htx_n <= htx_n + 1;
		if (dev_rx_valid === 1'b1) begin
			got_sample <= dev_rx_sample;
			dev_rx_n <= dev_rx_n + 1;
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		cmp_count++;
		if (seen !== want) begin
			fail_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask

	task automatic stop_test();
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// reference expansion of one 8-bit code to the 16-bit linear scale
	function automatic logic [15:0] expand(input logic [7:0] c, input logic mu);
		logic [7:0] u;
		logic [15:0] t;
		if (mu) begin
			u = ~c;
			t = (({12'h000, u[3:0]} << 3) + 16'h0084) << u[6:4];
			expand = u[7] ? 16'h0084 - t : t - 16'h0084;
		end else begin
			u = c ^ 8'h55;
			t = {12'h000, u[3:0]} << 4;
			t = (u[6:4] == 3'h0) ? t + 16'h0008 : (t + 16'h0108) << (u[6:4] - 3'h1);
			expand = u[7] ? t : 16'h0000 - t;
		end
	endfunction

	// one format and law: send a code each way, let it settle, compare both ends
	task automatic run(input pcm_pkg::pcm_mode_type m, input logic ch, input logic mu, input logic [7:0] hc,
		input logic [7:0] dc);
		mode_sel = m;
		chan_sel = ch;
		law_mu = mu;
		tx_byte = hc;
		tx_sample = expand(dc, mu);
		tick(6 * FRAME);
		dev_rx_n = 0;
		tx_n = 0;
		htx_n = 0;
		tick(2 * FRAME);
		check(16'(dev_rx_n), 16'h0002);
		check(16'(tx_n), 16'h0002);
		check(16'(htx_n), 16'h0002);
		check(got_sample, expand(hc, mu));
		check({8'h00, got_byte}, {8'h00, dc});
		check({14'h0000, dev_mode}, {14'h0000, m});
		check({15'h0000, channel}, {15'h0000, (m == pcm_pkg::PCM_FRAME) ? 1'b0 : ch});
		check(frame_period, 16'(FRAME));
	endtask

	// main sequence
	initial begin
		fail_count = 0;
		cmp_count = 0;
		dev_rx_n = 0;
		tx_n = 0;
		htx_n = 0;
		rst_n = 1'b0;
		mode_sel = pcm_pkg::PCM_FRAME;
		chan_sel = 1'b0;
		law_mu = 1'b1;
		power_up = 1'b1;
		tx_byte = 8'h00;
		tx_sample = 16'h0000;
		tick(5);
		rst_n = 1'b1;
		for (k = 0; k < 10; k++)
			run((k < 2) ? pcm_pkg::PCM_FRAME : ((k < 6) ? pcm_pkg::PCM_GCI : pcm_pkg::PCM_IDL), (k / 2) % 2 == 1 && k > 1,
				k % 2 == 0, 8'h1A + 8'(k * 23), 8'hC3 - 8'(k * 19));
		// power down, then power up with the output guard
		power_up = 1'b0;
		tick(8);
		check({15'h0000, powered}, 16'h0000);
		dev_rx_n = 0;
		tx_n = 0;
		tick(2 * FRAME);
		check(16'(dev_rx_n), 16'h0000);
		check(16'(tx_n), 16'h0000);
		check({15'h0000, link.serial_data_out_oe}, 16'h0000);
		power_up = 1'b1;
		w = 0;
		while (powered !== 1'b1 && w < 10) begin
			tick(1);
			w++;
		end
		if (w == 10) begin
			fail_count++;
			stop_test();
		end
		run(pcm_pkg::PCM_FRAME, 1'b0, 1'b1, 8'h5C, 8'hA7);
		// reset in mid-run, then a fresh transfer
		rst_n = 1'b0;
		tick(5);
		rst_n = 1'b1;
		check({14'h0000, dev_mode}, 16'h0000);
		run(pcm_pkg::PCM_IDL, 1'b1, 1'b0, 8'h3D, 8'hE2);
		stop_test();
	end
endmodule
